// ===== lcf_pkg.sv
`default_nettype none
package lcf_pkg;
  // register map, byte addresses
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_RATE      = 4'h4;
  localparam logic [3:0] REG_STATUS    = 4'h8;
  localparam logic [3:0] REG_CREDIT    = 4'hC;
  // control fields
  localparam int CTRL_DISABLE_BIT     = 0;
  localparam int CTRL_START_BIT       = 1;
  localparam int CTRL_AUTO_BIT        = 2;
  localparam int CTRL_PRESET_BIT      = 3;
  localparam logic [2:0] CTRL_RESET   = 3'h1;
  // status fields
  localparam int STAT_STATE_LSB       = 0;
  localparam int STAT_ERR_LSB         = 4;
  localparam int CRED_TX_LSB          = 0;
  localparam int CRED_RX_LSB          = 8;
  // credit figures
  localparam logic [5:0] CRED_STEP    = 6'h08;
  localparam logic [5:0] CRED_MAX     = 6'h38;
  // timing
  localparam int CLK_PERIOD_NS        = 50;
  localparam int CLK_MHZ              = 20;
  localparam int T_RESET_NS           = 6400;
  localparam int T_WAIT_NS            = 12800;
  localparam logic [8:0] T_RESET_CYC  = 9'(T_RESET_NS / CLK_PERIOD_NS);
  localparam logic [8:0] T_WAIT_CYC   = 9'(T_WAIT_NS / CLK_PERIOD_NS);
  // signalling rates, in Mb/s, and clock dividers per bit
  localparam int RATE_INIT_MBPS       = 10;
  localparam int RATE_MIN_MBPS        = 2;
  localparam int RATE_MAX_MBPS        = 10;
  localparam logic [3:0] DIV_INIT     = 4'(CLK_MHZ / RATE_INIT_MBPS);
  localparam logic [3:0] DIV_SLOW     = 4'(CLK_MHZ / RATE_MIN_MBPS);
  localparam logic [3:0] DIV_FAST     = 4'(CLK_MHZ / RATE_MAX_MBPS);
  // character kinds on the encoding layer side
  typedef enum logic [1:0] {
    KIND_NULL,
    KIND_FCT,
    KIND_NCHAR,
    KIND_BC
  } lcf_kind_t;
  typedef enum logic [2:0] {
    ST_ERR_RESET,
    ST_ERR_WAIT,
    ST_READY,
    ST_STARTED,
    ST_CONNECTING,
    ST_RUN
  } lcf_state_t;
endpackage : lcf_pkg
`default_nettype wire

// ===== lcf_link_ctrl.sv
// What this block does
// RULE1 - after reset or disconnect transmit at the ten megabit initial rate
// RULE2 - transmit rate reaches down to two megabits per second
// RULE3 - fastest supported rate is declared and never below initial rate
// RULE4 - transmit rate set per port, independent of far end
// RULE5 - a per-port link speed setting selects the running rate
// RULE6 - exchange N-Chars and broadcast codes with network layer, with ready flags
// RULE7 - drive transmit and receive enable flags to the encoding layer
// RULE8 - react to disconnect, receive error and first Null status
// RULE9 - port reset resets the port; link disable holds it off
// RULE10 - link start sends Nulls; auto start starts once a Null arrives
// RULE11 - expose link state, error flags and both credit counters
// RULE12 - one token buys eight N-Chars; send one only when ready for eight
// RULE13 - no N-Char goes out before a token has arrived
// RULE14 - transmit credit up eight per token in, down one per N-Char out
// RULE15 - at zero credit stop N-Chars, keep tokens, Nulls, broadcast codes
// RULE16 - both credit counters clear on entering the error reset state
// RULE17 - transmit credit never above fifty-six, seven tokens
// RULE18 - a token pushing transmit credit past its ceiling is a credit error
// RULE19 - at start-up send one token per eight free slots, seven at most
// RULE20 - receive credit up eight per token out, down one per N-Char in
// RULE21 - receive credit never above fifty-six
// RULE22 - token only when room for eight more and credit eight below ceiling
// RULE23 - N-Char arriving at zero receive credit is a credit error
// RULE24 - send order: broadcast code, token, N-Char, then Null
// RULE25 - credit counters six bits wide
`timescale 1ns/1ps
`default_nettype none
module lcf_link_ctrl (
  input  wire logic                 i_clock,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_clk_en,
  // register port
  input  wire logic [3:0]           i_reg_addr,
  input  wire logic [31:0]          i_reg_wdata,
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  output logic      [31:0]          o_reg_rdata,
  // network layer, transmit side
  input  wire logic                 i_tx_valid,
  input  wire logic [8:0]           i_tx_data,
  output logic                      o_tx_ready,
  input  wire logic                 i_bc_valid,
  input  wire logic [7:0]           i_bc_data,
  output logic                      o_bc_ready,
  // network layer, receive side
  input  wire logic [6:0]           i_rx_space,
  output logic                      o_rx_valid,
  output logic      [8:0]           o_rx_data,
  output logic                      o_bc_rx_valid,
  output logic      [7:0]           o_bc_rx_data,
  // encoding layer, transmit side
  input  wire logic                 i_enc_req,
  output logic                      o_enc_valid,
  output lcf_pkg::lcf_kind_t        o_enc_kind,
  output logic      [8:0]           o_enc_data,
  output logic      [3:0]           o_tx_div,
  output logic                      o_tx_enable,
  output logic                      o_rx_enable,
  // encoding layer, receive side
  input  wire logic                 i_dec_valid,
  input  wire lcf_pkg::lcf_kind_t   i_dec_kind,
  input  wire logic [8:0]           i_dec_data,
  input  wire logic                 i_disconnect,
  input  wire logic                 i_parity_err,
  input  wire logic                 i_esc_err,
  input  wire logic                 i_got_null
);
  import lcf_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // status flags from the link-clocked decoder

  localparam int NSYNC = 4;
  wire  [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync_a_ff;
  logic [NSYNC-1:0] sync_b_ff;
  logic [NSYNC-1:0] sync_c_ff;
  logic [NSYNC-1:0] flag_ff;

  assign async_in = {i_got_null, i_esc_err, i_parity_err, i_disconnect};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      // a level counts only once two settled stages agree
      always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
          sync_a_ff[g] <= 1'b0;
          sync_b_ff[g] <= 1'b0;
          sync_c_ff[g] <= 1'b0;
          flag_ff[g]   <= 1'b0;
        end else if (i_clk_en) begin
          sync_a_ff[g] <= async_in[g];
          sync_b_ff[g] <= sync_a_ff[g];
          sync_c_ff[g] <= sync_b_ff[g];
          if (sync_b_ff[g] == sync_c_ff[g]) begin
            flag_ff[g] <= sync_c_ff[g];
          end
        end
      end
    end
  endgenerate

  wire disc_s     = flag_ff[0];
  wire par_s      = flag_ff[1];
  wire esc_s      = flag_ff[2];
  wire got_null_s = flag_ff[3];

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic [2:0]  ctrl_ff;
  logic [3:0]  rate_ff;
  logic [3:0]  err_ff;
  logic        preset_ff;
  logic [31:0] rdata_ff;

  lcf_state_t  state_ff;
  lcf_state_t  nxt_state;
  logic [8:0]  timer_ff;
  logic [5:0]  tx_cred_ff;
  logic [5:0]  rx_cred_ff;
  logic        sent_null_ff;
  logic        sent_fct_ff;
  logic        bc_pend_ff;
  logic [7:0]  bc_buf_ff;

  wire wr_ctrl   = i_reg_wr && (i_reg_addr == REG_CTRL);
  wire wr_rate   = i_reg_wr && (i_reg_addr == REG_RATE);
  wire wr_status = i_reg_wr && (i_reg_addr == REG_STATUS);

  wire link_dis  = ctrl_ff[CTRL_DISABLE_BIT];
  wire link_go   = ctrl_ff[CTRL_START_BIT];
  wire auto_go   = ctrl_ff[CTRL_AUTO_BIT];

  // clamp to the supported range: 2 Mb/s slowest, 10 Mb/s fastest
  wire [3:0] rate_wr = i_reg_wdata[3:0];
  wire [3:0] rate_clamped = (rate_wr > DIV_SLOW) ? DIV_SLOW :  // [RULE2]
                            (rate_wr < DIV_FAST) ? DIV_FAST :  // [RULE3]
                            rate_wr;

  wire [31:0] stat_word = {24'h00_0000, err_ff,
                           1'b0, 3'(state_ff)};
  wire [31:0] cred_word = {18'h0_0000, rx_cred_ff,
                           2'b00, tx_cred_ff};  // [RULE11]
  wire [31:0] rd_mux =
    (i_reg_addr == REG_CTRL)   ? {29'h0000_0000, ctrl_ff} :
    (i_reg_addr == REG_RATE)   ? {28'h000_0000, rate_ff}  :
    (i_reg_addr == REG_STATUS) ? stat_word                :
    (i_reg_addr == REG_CREDIT) ? cred_word                :
    32'h0000_0000;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_ff   <= CTRL_RESET;
      rate_ff   <= DIV_INIT;
      preset_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
    end else if (i_clk_en) begin
      if (wr_ctrl) begin
        ctrl_ff <= i_reg_wdata[2:0];  // [RULE9] [RULE10]
      end
      // port reset is a self-clearing pulse
      preset_ff <= wr_ctrl && i_reg_wdata[CTRL_PRESET_BIT];
      if (wr_rate) begin
        rate_ff <= rate_clamped;  // [RULE5]
      end
      rdata_ff <= i_reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign o_reg_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // receive side decode

  wire in_rx_phase = (state_ff != ST_ERR_RESET);
  wire rx_live     = in_rx_phase && got_null_s;
  wire rx_fct      = rx_live && i_dec_valid && (i_dec_kind == KIND_FCT);
  wire rx_nchar    = rx_live && i_dec_valid && (i_dec_kind == KIND_NCHAR);
  wire rx_bc       = rx_live && i_dec_valid && (i_dec_kind == KIND_BC);
  wire rx_any      = rx_fct || rx_nchar || rx_bc;
  wire run         = (state_ff == ST_RUN);
  wire connecting  = (state_ff == ST_CONNECTING);

  wire cred_err_tx = rx_fct && (tx_cred_ff > (CRED_MAX - CRED_STEP));  // [RULE18]
  wire cred_err_rx = rx_nchar && (rx_cred_ff == 6'h00);  // [RULE23]
  wire cred_err    = run && (cred_err_tx || cred_err_rx);
  wire link_err    = disc_s || par_s || esc_s;  // [RULE8]

  ////////////////////////////////////////////////////////////////////////
  // link state sequencing

  wire t_reset_done = (timer_ff >= T_RESET_CYC);
  wire t_wait_done  = (timer_ff >= T_WAIT_CYC);
  wire kill         = link_dis || link_err;  // [RULE9]

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_ERR_RESET: begin
        if (t_reset_done && !link_dis) nxt_state = ST_ERR_WAIT;
      end
      ST_ERR_WAIT: begin
        if (kill || rx_any) nxt_state = ST_ERR_RESET;
        else if (t_wait_done) nxt_state = ST_READY;
      end
      ST_READY: begin
        if (kill || rx_any) nxt_state = ST_ERR_RESET;
        else if (link_go || (auto_go && got_null_s)) nxt_state = ST_STARTED;  // [RULE10]
      end
      ST_STARTED: begin
        if (kill || rx_any || t_wait_done) nxt_state = ST_ERR_RESET;
        else if (got_null_s && sent_null_ff) nxt_state = ST_CONNECTING;
      end
      ST_CONNECTING: begin
        if (kill || rx_nchar || rx_bc || t_wait_done) nxt_state = ST_ERR_RESET;
        else if (rx_fct && sent_fct_ff) nxt_state = ST_RUN;
      end
      ST_RUN: begin
        if (kill || cred_err) nxt_state = ST_ERR_RESET;
      end
    endcase
    if (preset_ff) nxt_state = ST_ERR_RESET;  // [RULE9]
  end

  wire enter_reset = (nxt_state == ST_ERR_RESET) && (state_ff != ST_ERR_RESET);

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= ST_ERR_RESET;
      timer_ff <= 9'h000;
    end else if (i_clk_en) begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff) timer_ff <= 9'h000;
      else if (!t_wait_done) timer_ff <= timer_ff + 9'h001;
    end
  end

  // receiver runs from error wait on; transmitter from started on
  assign o_rx_enable = in_rx_phase;  // [RULE7]
  assign o_tx_enable = (state_ff == ST_STARTED) || connecting || run;  // [RULE7]
  // back to the initial rate whenever the link is not running
  assign o_tx_div = run ? rate_ff : DIV_INIT;  // [RULE1] [RULE4]

  ////////////////////////////////////////////////////////////////////////
  // transmit selection

  wire [6:0] rx_owed  = {1'b0, rx_cred_ff} + {1'b0, CRED_STEP};
  wire fct_room = (rx_cred_ff <= (CRED_MAX - CRED_STEP)) &&  // [RULE21] [RULE22]
                  (i_rx_space >= rx_owed);  // [RULE12] [RULE19]
  wire fct_ok   = (connecting || run) && fct_room;
  wire take     = i_enc_req && o_tx_enable;
  wire pick_bc  = take && run && bc_pend_ff;  // [RULE24]
  wire pick_fct = take && !pick_bc && fct_ok;  // [RULE24]
  // zero credit blocks data only; tokens, Nulls and codes still flow
  wire pick_nc  = take && run && !bc_pend_ff && !fct_ok &&
                  i_tx_valid && (tx_cred_ff != 6'h00);  // [RULE13] [RULE15]
  wire pick_nul = take && !pick_bc && !pick_fct && !pick_nc;  // [RULE24]

  assign o_tx_ready = pick_nc;  // [RULE6]
  assign o_bc_ready = !bc_pend_ff && run;  // [RULE6]

  wire bc_load = i_bc_valid && o_bc_ready;

  lcf_kind_t kind_ff;
  logic [8:0] enc_data_ff;
  logic enc_valid_ff;

  wire lcf_kind_t pick_kind = pick_bc  ? KIND_BC  :
                              pick_fct ? KIND_FCT :
                              pick_nc  ? KIND_NCHAR : KIND_NULL;
  wire [8:0] pick_data = pick_bc ? {1'b0, bc_buf_ff} :
                         pick_nc ? i_tx_data : 9'h000;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      kind_ff      <= KIND_NULL;
      enc_data_ff  <= 9'h000;
      enc_valid_ff <= 1'b0;
    end else if (i_clk_en) begin
      enc_valid_ff <= take;
      if (take) begin
        kind_ff     <= pick_kind;
        enc_data_ff <= pick_data;
      end
    end
  end

  assign o_enc_valid = enc_valid_ff;
  assign o_enc_kind  = kind_ff;
  assign o_enc_data  = enc_data_ff;

  // pending broadcast code is dropped on error reset
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bc_pend_ff   <= 1'b0;
      bc_buf_ff    <= 8'h00;
      sent_null_ff <= 1'b0;
      sent_fct_ff  <= 1'b0;
    end else if (i_clk_en) begin
      if (nxt_state == ST_ERR_RESET) bc_pend_ff <= 1'b0;
      else if (bc_load) bc_pend_ff <= 1'b1;
      else if (pick_bc) bc_pend_ff <= 1'b0;
      if (bc_load) bc_buf_ff <= i_bc_data;
      if (!o_tx_enable) sent_null_ff <= 1'b0;
      else if (pick_nul) sent_null_ff <= 1'b1;
      if (!o_tx_enable) sent_fct_ff <= 1'b0;
      else if (pick_fct) sent_fct_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // credit counters, six bits to cover 0..56

  wire [5:0] tx_up  = (tx_cred_ff > (CRED_MAX - CRED_STEP)) ?
                      CRED_MAX : (tx_cred_ff + CRED_STEP);  // [RULE17]
  wire [5:0] tx_dn  = tx_cred_ff - 6'h01;
  wire [5:0] nxt_tx = (rx_fct && pick_nc) ? (tx_up - 6'h01) :
                      rx_fct  ? tx_up :  // [RULE14]
                      pick_nc ? tx_dn :  // [RULE14]
                      tx_cred_ff;
  wire rx_dec       = rx_nchar && run && (rx_cred_ff != 6'h00);
  wire [5:0] nxt_rx = (pick_fct && rx_dec) ? (rx_cred_ff + CRED_STEP - 6'h01) :
                      pick_fct ? (rx_cred_ff + CRED_STEP) :  // [RULE20]
                      rx_dec   ? (rx_cred_ff - 6'h01) :  // [RULE20]
                      rx_cred_ff;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_cred_ff <= 6'h00;
      rx_cred_ff <= 6'h00;
    end else if (i_clk_en) begin
      if (nxt_state == ST_ERR_RESET) begin
        tx_cred_ff <= 6'h00;  // [RULE16]
        rx_cred_ff <= 6'h00;  // [RULE16]
      end else begin
        tx_cred_ff <= nxt_tx;  // [RULE25]
        rx_cred_ff <= nxt_rx;  // [RULE25]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // delivery to the network layer and error flags

  wire [3:0] err_set = {cred_err, esc_s, par_s, disc_s};
  wire [3:0] err_clr = wr_status ? i_reg_wdata[STAT_ERR_LSB +: 4] : 4'h0;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rx_valid    <= 1'b0;
      o_rx_data     <= 9'h000;
      o_bc_rx_valid <= 1'b0;
      o_bc_rx_data  <= 8'h00;
      err_ff        <= 4'h0;
    end else if (i_clk_en) begin
      // characters are only passed up while running
      o_rx_valid    <= rx_nchar && run && !enter_reset;  // [RULE6]
      o_bc_rx_valid <= rx_bc && run && !enter_reset;  // [RULE6]
      if (rx_nchar) o_rx_data <= i_dec_data;
      if (rx_bc) o_bc_rx_data <= i_dec_data[7:0];
      // set wins over a clear in the same cycle
      err_ff <= (err_ff & ~err_clr) | err_set;  // [RULE11]
    end
  end

endmodule : lcf_link_ctrl
`default_nettype wire

// ===== lcf_link_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lcf_checker (
  input wire logic               i_clock,
  input wire logic               i_reset_n,
  input wire logic               i_reg_rd,
  input wire logic [31:0]        o_reg_rdata,
  input wire logic               i_tx_valid,
  input wire logic [8:0]         i_tx_data,
  input wire logic               o_tx_ready,
  input wire logic               i_enc_req,
  input wire logic               o_enc_valid,
  input wire lcf_pkg::lcf_kind_t o_enc_kind,
  input wire logic [8:0]         o_enc_data,
  input wire logic [3:0]         o_tx_div,
  input wire logic               o_tx_enable,
  input wire logic               o_rx_enable,
  input wire logic               i_dec_valid,
  input wire lcf_pkg::lcf_kind_t i_dec_kind,
  input wire logic [8:0]         i_dec_data,
  input wire logic               o_rx_valid,
  input wire logic [8:0]         o_rx_data,
  input wire logic               o_bc_rx_valid,
  input wire logic [7:0]         o_bc_rx_data,
  input wire logic               i_disconnect
);
  import lcf_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////////////////
  enc_answer_a: assert property (o_enc_valid == $past(i_enc_req && o_tx_enable))
    else $error("encoder answer without request");
  rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  init_rate_a: assert property (!o_tx_enable |-> o_tx_div == DIV_INIT)
    else $error("rate not initial while idle");
  rx_with_tx_a: assert property (o_tx_enable |-> o_rx_enable)
    else $error("transmitter on with receiver off");
  nchar_out_a: assert property (o_tx_ready |-> i_enc_req && i_tx_valid && o_tx_enable
    ##1 o_enc_valid && o_enc_kind == KIND_NCHAR && o_enc_data == $past(i_tx_data))
    else $error("nchar hand-over wrong");
  rx_pass_a: assert property (o_rx_valid |-> $past(i_dec_valid && i_dec_kind == KIND_NCHAR)
    && o_rx_data == $past(i_dec_data)) else $error("received nchar wrong");
  bc_pass_a: assert property (o_bc_rx_valid |-> $past(i_dec_valid && i_dec_kind == KIND_BC)
    && o_bc_rx_data == $past(i_dec_data[7:0])) else $error("received code wrong");
  disc_stop_a: assert property (i_disconnect [*6] |-> !o_tx_enable)
    else $error("transmitter on after disconnect");
  cover property (o_tx_ready);
  cover property (o_rx_valid);
  cover property (o_bc_rx_valid);
endmodule : lcf_checker
bind lcf_link_ctrl lcf_checker chk (.i_clock, .i_reset_n, .i_reg_rd, .o_reg_rdata, .i_tx_valid, .i_tx_data,
  .o_tx_ready, .i_enc_req, .o_enc_valid, .o_enc_kind, .o_enc_data, .o_tx_div, .o_tx_enable, .o_rx_enable,
  .i_dec_valid, .i_dec_kind, .i_dec_data, .o_rx_valid, .o_rx_data, .o_bc_rx_valid, .o_bc_rx_data, .i_disconnect);
`default_nettype wire

// ===== lcf_enc_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcf_enc_model (
  input  wire logic               i_clock,
  input  wire logic               i_reset_n,
  input  wire logic               i_tx_enable,
  input  wire logic               i_rx_enable,
  input  wire logic               i_enc_valid,
  input  wire lcf_pkg::lcf_kind_t i_enc_kind,
  input  wire logic [8:0]         i_enc_data,
  output var  logic               o_enc_req,
  output var  logic               o_dec_valid,
  output var  lcf_pkg::lcf_kind_t o_dec_kind,
  output var  logic [8:0]         o_dec_data,
  output logic                    o_got_null
);
  import lcf_pkg::*;
  logic       lclk = 1'b0;
  logic [2:0] ls_ff;
  logic [4:0] gn_ff;
  logic [8:0] last_chr;
  logic [8:0] last_bc;
  int         nfct = 0;
  int         nchr = 0;
  int         nrx = 0;
  ////////////////////////////////////////////////////////////////////////
  // link clock stands still while the transmitter is held off
  initial begin
    o_dec_valid = 1'b0;
    o_dec_kind = KIND_NCHAR;
    o_dec_data = 9'h0A5;
    #37;
    forever begin
      #200;
      if (i_tx_enable) lclk = ~lclk;
    end
  end
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ls_ff <= 3'h0;
      o_enc_req <= 1'b0;
      gn_ff <= 5'h00;
    end else begin
      ls_ff <= {ls_ff[1:0], lclk};
      o_enc_req <= ls_ff[1] & ~ls_ff[2];
      gn_ff <= i_rx_enable ? gn_ff + 5'(gn_ff != 5'h1F) : 5'h00;
    end
  end
  assign o_got_null = gn_ff == 5'h1F;
  always @(posedge i_clock) begin
    if (i_enc_valid && i_enc_kind == KIND_FCT) nfct <= nfct + 1;
    if (i_enc_valid && i_enc_kind == KIND_NCHAR) nchr <= nchr + 1;
    if (i_enc_valid && i_enc_kind == KIND_NCHAR) last_chr <= i_enc_data;
    if (i_enc_valid && i_enc_kind == KIND_BC) last_bc <= i_enc_data;
  end
  // nchars only inside the credit this end has granted
  task automatic send(input lcf_kind_t k, input logic [8:0] d);
    if (k != KIND_NCHAR || nrx < nfct * 8) begin
      @(posedge i_clock);
      o_dec_valid <= 1'b1;
      o_dec_kind <= k;
      o_dec_data <= d;
      nrx = nrx + int'(k == KIND_NCHAR);
      @(posedge i_clock);
      o_dec_valid <= 1'b0;
      o_dec_kind <= lcf_kind_t'(~k);
      o_dec_data <= ~d;
    end
  endtask : send
endmodule : lcf_enc_model
`default_nettype wire

// ===== tb_lcf_link_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_lcf_link_ctrl;
  import lcf_pkg::*;
  logic       i_clock = 1'b0, i_reset_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [3:0] i_reg_addr = 4'h0;
  logic [31:0] i_reg_wdata = 32'h0000_0000, o_reg_rdata;
  logic [8:0] i_tx_data = 9'h000, o_rx_data, o_enc_data, i_dec_data, got_rx;
  logic       i_bc_valid = 1'b0, i_disconnect = 1'b0, o_tx_ready, o_bc_ready, o_rx_valid, o_bc_rx_valid;
  logic [7:0] i_bc_data = 8'hA5, o_bc_rx_data, got_bc;
  logic [6:0] i_rx_space = 7'h28;
  logic       i_enc_req, o_enc_valid, o_tx_enable, o_rx_enable, i_dec_valid, i_got_null;
  logic [3:0] o_tx_div;
  lcf_kind_t  o_enc_kind, i_dec_kind;
  wire        i_tx_valid;
  int         tx_left = 0, fails = 0, compares = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////////////
  lcf_link_ctrl uut (.i_clock, .i_reset_n, .i_clk_en(1'b1), .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
    .o_reg_rdata, .i_tx_valid, .i_tx_data, .o_tx_ready, .i_bc_valid, .i_bc_data, .o_bc_ready, .i_rx_space,
    .o_rx_valid, .o_rx_data, .o_bc_rx_valid, .o_bc_rx_data, .i_enc_req, .o_enc_valid, .o_enc_kind, .o_enc_data,
    .o_tx_div, .o_tx_enable, .o_rx_enable, .i_dec_valid, .i_dec_kind, .i_dec_data, .i_disconnect,
    .i_parity_err(1'b0), .i_esc_err(1'b0), .i_got_null);
  lcf_enc_model m (.i_clock, .i_reset_n, .i_tx_enable(o_tx_enable), .i_rx_enable(o_rx_enable),
    .i_enc_valid(o_enc_valid), .i_enc_kind(o_enc_kind), .i_enc_data(o_enc_data), .o_enc_req(i_enc_req),
    .o_dec_valid(i_dec_valid), .o_dec_kind(i_dec_kind), .o_dec_data(i_dec_data), .o_got_null(i_got_null));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 i_clock = ~i_clock;
  end
  assign i_tx_valid = tx_left != 0;
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (o_tx_ready) i_tx_data <= i_tx_data + 9'h001;
    if (o_tx_ready) tx_left <= tx_left - 1;
    if (o_rx_valid) got_rx <= o_rx_data;
    if (o_bc_rx_valid) got_bc <= o_bc_rx_data;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clock);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clock);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask : rd
  task automatic rck(input string n, input logic [3:0] a, input int s, input logic [31:0] msk, e);
    logic [31:0] v;
    rd(a, v);
    check(n, e, (v >> s) & msk);
  endtask : rck
  // polls the state field; a transient state can slip between two reads
  task automatic wait_state(input logic [2:0] s);
    logic [31:0] v;
    v = {29'h0, ~s};
    for (int i = 0; i < 400 && v[2:0] !== s; i++) rd(REG_STATUS, v);
    check("state", 32'(s), 32'(v[2:0]));
  endtask : wait_state
  task automatic link_up;
    wait_state(ST_CONNECTING);
    // connecting moves on only if our own token has already gone out
    repeat (20) @(posedge i_clock);
    m.send(KIND_FCT, 9'h000);
    wait_state(ST_RUN);
    repeat (100) @(posedge i_clock);
  endtask : link_up
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge i_clock);
    i_reset_n <= 1'b1;
    rck("ctrl", REG_CTRL, 0, 32'hF, 32'h1);
    check("div", 32'(DIV_INIT), 32'(o_tx_div));
    wr(REG_RATE, 32'h0000_0001);
    rck("rate low", REG_RATE, 0, 32'hF, 32'(DIV_FAST));
    wr(REG_RATE, 32'h0000_000F);
    rck("rate high", REG_RATE, 0, 32'hF, 32'(DIV_SLOW));
    rck("unmapped", 4'h2, 0, 32'hFFFF_FFFF, 32'h0);
    wr(REG_CTRL, 32'h0000_0002);
    link_up();
    rck("rx credit", REG_CREDIT, 8, 32'h3F, 32'd40);
    rck("tx credit", REG_CREDIT, 0, 32'h3F, 32'd8);
    check("div run", 32'(DIV_SLOW), 32'(o_tx_div));
    tx_left <= 9;
    repeat (150) @(posedge i_clock);
    check("sent", 32'd8, 32'(m.nchr));
    rck("tx credit", REG_CREDIT, 0, 32'h3F, 32'd0);
    m.send(KIND_FCT, 9'h000);
    repeat (60) @(posedge i_clock);
    check("sent", 32'd9, 32'(m.nchr));
    check("last", 32'h8, 32'(m.last_chr));
    m.send(KIND_NCHAR, 9'h05A);
    repeat (3) @(posedge i_clock);
    check("rx data", 32'h5A, 32'(got_rx));
    rck("rx credit", REG_CREDIT, 8, 32'h3F, 32'd39);
    @(posedge i_clock);
    i_bc_valid <= 1'b1;
    @(posedge i_clock);
    for (int i = 0; i < 50 && o_bc_ready !== 1'b1; i++) @(posedge i_clock);
    i_bc_valid <= 1'b0;
    m.send(KIND_BC, 9'h03C);
    repeat (40) @(posedge i_clock);
    check("bc out", 32'hA5, 32'(m.last_bc[7:0]));
    check("bc in", 32'h3C, 32'(got_bc));
    repeat (6) m.send(KIND_FCT, 9'h000);
    rck("tx credit", REG_CREDIT, 0, 32'h3F, 32'd55);
    m.send(KIND_FCT, 9'h000);
    repeat (8) @(posedge i_clock);
    rck("credit err", REG_STATUS, 7, 32'h1, 32'h1);
    rck("credits", REG_CREDIT, 0, 32'h3F3F, 32'h0);
    wr(REG_CTRL, 32'h0000_0004);
    link_up();
    i_disconnect <= 1'b1;
    repeat (12) @(posedge i_clock);
    check("div", 32'(DIV_INIT), 32'(o_tx_div));
    rck("disc err", REG_STATUS, 4, 32'h1, 32'h1);
    i_disconnect <= 1'b0;
    repeat (8) @(posedge i_clock);
    wr(REG_STATUS, 32'h0000_00F0);
    rck("errors", REG_STATUS, 4, 32'hF, 32'h0);
    link_up();
    wr(REG_CTRL, 32'h0000_000C);
    rck("port reset", REG_STATUS, 0, 32'h7, 32'(ST_ERR_RESET));
    rck("ctrl", REG_CTRL, 0, 32'hF, 32'h4);
    wr(REG_CTRL, 32'h0000_0001);
    repeat (500) @(posedge i_clock);
    rck("state", REG_STATUS, 0, 32'h7, 32'(ST_ERR_RESET));
    check("rx en", 32'h0, 32'(o_rx_enable));
    give_verdict();
  end
endmodule : tb_lcf_link_ctrl
`default_nettype wire
